// [tb/bbcc_core_asserts.sv]
// port assertions for the instruction unit
`timescale 1ns/1ps
module bbcc_chk (
   input logic clk,
   input logic rst_n,
   input logic [15:0] instr,
   input logic instr_valid,
   input logic [3:0] phase,
   input logic instr_take,
   input logic [20:0] pc_q,
   input logic [4:0] flags_q,
   input logic mem_we,
   input logic [7:0] mem_wdata,
   input logic stack_push,
   input logic timeout_flag,
   input logic powerdown_flag,
   input logic watchdog_clear,
   input logic busy_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire go = instr_take && instr_valid;
   ////////////////////////////////////////////////////////////////////////////
   phase_ring_a: assert property (1 |=> phase == {$past(phase[2:0]), $past(phase[3])})
      else $error("phase ring broken");
   take_phase_a: assert property (instr_take |-> phase == 4'h1)
      else $error("take outside decode phase");
   we_pulse_a: assert property (mem_we |=> !mem_we)
      else $error("write strobe too long");
   tog_flags_a: assert property (go && instr[15:12] == 4'h7 |=> $stable(flags_q)[*4])
      else $error("toggle moved flags");
   zero_fall_a: assert property (go && instr[15:8] == 8'hE0 && !flags_q[2]
      |-> ##4 pc_q == $past(pc_q, 4) + 21'h000002 && !busy_q) else $error("zero fall wrong");
   ovf_fall_a: assert property (go && instr[15:8] == 8'hE4 && !flags_q[3]
      |-> ##4 pc_q == $past(pc_q, 4) + 21'h000002 && flags_q == $past(flags_q, 4))
      else $error("overflow fall wrong");
   zero_take_a: assert property (go && instr[15:8] == 8'hE0 && flags_q[2] |-> ##5 busy_q)
      else $error("taken branch not two cycles");
   clr_data_a: assert property (go && instr[15:9] == 7'h35
      |-> ##[1:4] (mem_we && mem_wdata == 8'h00)) else $error("clear wrote nonzero");
   call_push_a: assert property (go && instr[15:9] == 7'h76 |-> ##[1:8] stack_push)
      else $error("call without push");
   wd_flags_a: assert property (go && instr == 16'h0004
      |-> ##[1:4] watchdog_clear ##[0:3] (timeout_flag && powerdown_flag))
      else $error("watchdog clear wrong");
endmodule // bbcc_chk
bind bbcc_core bbcc_chk u_chk (.*);

// [tb/testbench.sv]
// self-checking bench for the instruction unit
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
   $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic ext_mode = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [11:0] index_base = 12'h100;
   logic [11:0] mem_addr;
   logic [7:0] mem_rdata, mem_wdata, working_q, working_shadow;
   logic [20:0] pc_q, top_of_stack, p;
   logic [4:0] flags_q, flags_shadow;
   logic [3:0] phase, bank_select_register, bank_select_shadow;
   logic mem_we, instr_take, stack_push, timeout_flag, powerdown_flag, watchdog_clear, busy_q;
   logic [7:0] mem [0:4095];
   int failures = 0;
   int checked = 0;
   bbcc_core DUT (.*);
   always #20 clk = ~clk;
   // memory answers in the same cycle, as the core expects
   assign mem_rdata = mem[mem_addr];
   always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
   ////////////////////////////////////////////////////////////////////////////
   task automatic idle();
      int n;
      n = 0;
      @(negedge clk);
      while (instr_take !== 1'b1 && n < 40) begin
         n++;
         @(negedge clk);
      end
   endtask
   task automatic issue(input logic [15:0] w, input logic x = 1'b0);
      @(posedge clk);
      instr <= w;
      ext_mode <= x;
      instr_valid <= 1'b1;
      idle();
      p = pc_q;
      @(posedge clk);
      instr_valid <= 1'b0;
      idle();
      // let the write strobe land in the memory before judging
      @(negedge clk);
   endtask
   task automatic end_sim();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_toggle();
      logic [15:0] w [3] = '{16'h7359, 16'h7A00, 16'h710E};
      logic [11:0] a [3] = '{12'h035, 12'hFA0, 12'h110};
      logic [7:0] e [3] = '{8'h65, 8'h01, 8'h80};
      mem[12'h035] = 8'h75;
      mem[12'hFA0] = 8'h00;
      mem[12'h110] = 8'h00;
      for (int i = 0; i < 3; i++) begin
         issue(w[i], i == 2);
         `CHK("toggled byte", e[i], mem[a[i]])
         `CHK("pc", p + 21'h000002, pc_q)
      end
      $display("toggle done");
   endtask
   task automatic t_branch();
      issue(16'hE005);
      `CHK("pc zero fall", p + 21'h000002, pc_q)
      issue(16'hE4F0);
      `CHK("pc ovf fall", p + 21'h000002, pc_q)
      mem[12'h040] = 8'h5A;
      issue(16'h6B40);
      `CHK("cleared byte", 8'h00, mem[12'h040])
      `CHK("zero flag", 1'b1, flags_q[2])
      issue(16'hE0FD);
      `CHK("pc back", p - 21'h000004, pc_q)
      issue(16'hE07F);
      `CHK("pc fwd", p + 21'h000100, pc_q)
      `CHK("zero kept", 1'b1, flags_q[2])
      $display("branch and clear done");
   endtask
   task automatic t_call(input logic s);
      logic [4:0] fs;
      logic [7:0] ws;
      fs = s ? flags_q : flags_shadow;
      ws = s ? working_q : working_shadow;
      @(posedge clk);
      instr <= {7'h76, s, 8'h34};
      instr_valid <= 1'b1;
      idle();
      p = pc_q;
      @(posedge clk);
      instr <= 16'hF567;
      repeat (4) @(posedge clk);
      instr_valid <= 1'b0;
      idle();
      `CHK("return", p + 21'h000004, top_of_stack)
      `CHK("target", 21'h0ACE68, pc_q)
      `CHK("flags shadow", fs, flags_shadow)
      `CHK("work shadow", ws, working_shadow)
      $display("call done");
   endtask
   task automatic t_compl();
      issue(16'h1D40);
      `CHK("working", 8'hFF, working_q)
      `CHK("file kept", 8'h00, mem[12'h040])
      $display("complement done");
   endtask
   task automatic t_wdog();
      logic [4:0] f;
      f = flags_q;
      issue(16'h0004);
      `CHK("timeout", 1'b1, timeout_flag)
      `CHK("powerdown", 1'b1, powerdown_flag)
      `CHK("flags", f, flags_q)
      $display("watchdog clear done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK("reset phase", 4'h1, phase)
      @(posedge clk);
      rst_n <= 1'b1;
      t_toggle();
      t_branch();
      t_call(1'b1);
      t_compl();
      t_call(1'b0);
      t_wdog();
      end_sim();
   end
   // about twenty times the expected run
   initial begin
      #100000;
      failures++;
      end_sim();
   end
endmodule // testbench

// [verilog/bbcc_addr.v]
// file address former: access bank, banked and indexed literal offset
`timescale 1ns/1ps
`include "bbcc_consts.vh"
module bbcc_addr (
   input wire [7:0] file_addr,
   input wire bank_sel,
   input wire ext_mode,
   input wire [3:0] bank_select_register,
   input wire [11:0] index_base,
   output wire [11:0] data_addr,
   output wire indexed
);
   // indexed literal offset only with bank bit clear in extended mode
   assign indexed = ext_mode & ~bank_sel & (file_addr <= `BBCC_IDX_LIMIT);
   // access bank: low 96 at bank 0, upper at bank 15
   assign data_addr = indexed ? (index_base + {4'h0, file_addr}) :
                      bank_sel ? {bank_select_register, file_addr} :
                      (file_addr >= `BBCC_ACC_SPLIT) ?
                      {4'hF, file_addr} : {4'h0, file_addr};
endmodule // bbcc_addr

// [verilog/bbcc_consts.vh]
// constants for the bit, branch, call and clear instruction unit
`ifndef BBCC_CONSTS_VH
`define BBCC_CONSTS_VH
`define BBCC_OP_TOGGLE 4'h7
`define BBCC_OP_BR_OV 8'hE4
`define BBCC_OP_BR_Z 8'hE0
`define BBCC_OP_CALL 7'h76
`define BBCC_OP_CALL2 4'hF
`define BBCC_OP_CLEAR 7'h35
`define BBCC_OP_COMPL 6'h07
`define BBCC_OP_WDCLR 16'h0004
`define BBCC_IDX_LIMIT 8'h5F
`define BBCC_ACC_SPLIT 8'h60
`define BBCC_ST_N 4
`define BBCC_ST_OV 3
`define BBCC_ST_Z 2
`define BBCC_PC_STEP 21'h000002
`define BBCC_CALL_RET 21'h000004
`define BBCC_FLAGS_RST 5'h00
`define BBCC_PC_RST 21'h000000
`endif

// [verilog/bbcc_core.v]
// decode and execute of toggle, branch, call, clear and watchdog clear
`timescale 1ns/1ps
`include "bbcc_consts.vh"
module bbcc_core (
   input wire clk,
   input wire rst_n,
   input wire [15:0] instr,
   input wire instr_valid,
   input wire ext_mode,
   input wire [11:0] index_base,
   input wire [7:0] mem_rdata,
   output reg [11:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg mem_we,
   output wire [3:0] phase,
   output wire instr_take,
   output reg [20:0] pc_q,
   output reg [20:0] top_of_stack,
   output reg stack_push,
   output reg [7:0] working_q,
   output reg [4:0] flags_q,
   output reg [3:0] bank_select_register,
   output reg [7:0] working_shadow,
   output reg [4:0] flags_shadow,
   output reg [3:0] bank_select_shadow,
   output reg timeout_flag,
   output reg powerdown_flag,
   output reg watchdog_clear,
   output reg busy_q
);
   ////////////////////////////////////////////////////////////
   localparam S_IDLE = 3'b001;
   localparam S_NOP = 3'b010;
   localparam S_CALL2 = 3'b100;

   reg [2:0] state_q;
   reg [15:0] ir_q;
   reg [7:0] rd_q;
   reg [7:0] klo_q;
   reg s_q;
   wire [11:0] f_addr;
   wire f_idx;
   // toggle keeps its address in the middle byte and its bank bit at the bottom
   wire tog_word = (ir_q[15:12] == `BBCC_OP_TOGGLE);
   wire [7:0] f_field = tog_word ? ir_q[11:4] : ir_q[7:0];
   wire a_field = tog_word ? ir_q[0] : ir_q[8];

   bbcc_phase u_phase (
      .clk(clk),
      .rst_n(rst_n),
      .phase(phase)
   );

   bbcc_addr u_addr (
      .file_addr(f_field),
      .bank_sel(a_field),
      .ext_mode(ext_mode),
      .bank_select_register(bank_select_register),
      .index_base(index_base),
      .data_addr(f_addr),
      .indexed(f_idx)
   );

   ////////////////////////////////////////////////////////////
   function is_toggle;
      input [15:0] w;
      is_toggle = (w[15:12] == `BBCC_OP_TOGGLE);
   endfunction
   function is_clear;
      input [15:0] w;
      is_clear = (w[15:9] == `BBCC_OP_CLEAR);
   endfunction
   function is_compl;
      input [15:0] w;
      is_compl = (w[15:10] == `BBCC_OP_COMPL);
   endfunction

   // instruction word is sampled in the decode phase while idle
   assign instr_take = phase[0] & (state_q == S_IDLE);

   wire [7:0] bit_mask = 8'h01 << ir_q[3:1];
   wire br_ov = (ir_q[15:8] == `BBCC_OP_BR_OV);
   wire br_z = (ir_q[15:8] == `BBCC_OP_BR_Z);
   wire br_take = (br_ov & flags_q[`BBCC_ST_OV]) | (br_z & flags_q[`BBCC_ST_Z]);
   wire is_call = (ir_q[15:9] == `BBCC_OP_CALL);
   // sign-extended offset doubled, added to the unstepped pc; the step is added when pc is written
   wire [20:0] br_target = pc_q + {{12{ir_q[7]}}, ir_q[7:0], 1'b0};

   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         ir_q <= 16'h0000;
         rd_q <= 8'h00;
         klo_q <= 8'h00;
         s_q <= 1'b0;
         busy_q <= 1'b0;
         pc_q <= `BBCC_PC_RST;
         top_of_stack <= `BBCC_PC_RST;
         stack_push <= 1'b0;
         working_q <= 8'h00;
         flags_q <= `BBCC_FLAGS_RST;
         bank_select_register <= 4'h0;
         working_shadow <= 8'h00;
         flags_shadow <= `BBCC_FLAGS_RST;
         bank_select_shadow <= 4'h0;
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
         watchdog_clear <= 1'b0;
         mem_addr <= 12'h000;
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
      end else begin
         stack_push <= 1'b0;
         watchdog_clear <= 1'b0;
         mem_we <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (phase[0]) begin
                  // decode phase latches the word
                  ir_q <= instr_valid ? instr : 16'h0000;
                  busy_q <= 1'b0;
               end
               if (phase[1]) begin
                  // read phase: operand address goes out, low literal kept
                  klo_q <= ir_q[7:0];
                  s_q <= ir_q[8];
                  mem_addr <= f_addr;
               end
               if (phase[2]) begin
                  if (is_toggle(ir_q)) begin
                     // operand is taken here, once the registered address has settled
                     rd_q <= mem_rdata ^ bit_mask;
                  end else if (is_clear(ir_q)) begin
                     rd_q <= 8'h00;
                     flags_q[`BBCC_ST_Z] <= 1'b1;
                  end else if (is_compl(ir_q)) begin
                     rd_q <= ~mem_rdata;
                     flags_q[`BBCC_ST_Z] <= (mem_rdata == 8'hFF);
                     flags_q[`BBCC_ST_N] <= ~mem_rdata[7];
                  end else if (ir_q == `BBCC_OP_WDCLR) begin
                     watchdog_clear <= 1'b1;
                     timeout_flag <= 1'b1;
                     powerdown_flag <= 1'b1;
                  end else if (is_call) begin
                     top_of_stack <= pc_q + `BBCC_CALL_RET;
                     stack_push <= 1'b1;
                     if (s_q) begin
                        working_shadow <= working_q;
                        flags_shadow <= flags_q;
                        bank_select_shadow <= bank_select_register;
                     end
                  end
               end
               if (phase[3]) begin
                  if (is_toggle(ir_q) | is_clear(ir_q) |
                      (is_compl(ir_q) & ir_q[9])) begin
                     mem_we <= 1'b1;
                     mem_wdata <= rd_q;
                     pc_q <= pc_q + `BBCC_PC_STEP;
                  end else if (is_compl(ir_q)) begin
                     working_q <= rd_q;
                     pc_q <= pc_q + `BBCC_PC_STEP;
                  end else if (br_take) begin
                     pc_q <= br_target + `BBCC_PC_STEP;
                     state_q <= S_NOP;
                     busy_q <= 1'b1;
                  end else if (is_call) begin
                     state_q <= S_CALL2;
                     busy_q <= 1'b1;
                  end else begin
                     pc_q <= pc_q + `BBCC_PC_STEP;
                  end
               end
            end
            S_CALL2: begin
               // second word supplies k<19:8>; pc written at its write phase
               if (phase[0]) begin
                  ir_q <= instr;
               end
               if (phase[3]) begin
                  if (ir_q[15:12] == `BBCC_OP_CALL2) begin
                     pc_q <= {ir_q[11:0], klo_q, 1'b0};
                  end
                  state_q <= S_IDLE;
               end
            end
            S_NOP: begin
               // flushed cycle, no operation
               if (phase[3]) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // bbcc_core

// [verilog/bbcc_phase.v]
// four-phase generator for the instruction cycle
`timescale 1ns/1ps
module bbcc_phase (
   input wire clk,
   input wire rst_n,
   output wire [3:0] phase
);
   reg [3:0] phase_q;
   // one-hot ring: decode, read, process, write
   always @(posedge clk) begin
      if (!rst_n) begin
         phase_q <= 4'h1;
      end else begin
         phase_q <= {phase_q[2:0], phase_q[3]};
      end
   end
   assign phase = phase_q;
endmodule // bbcc_phase
